// [design/oodt_timer.v]
`timescale 1ns/1ps
`default_nettype none
`include "oodt_defs.vh"

module oodt_timer #(
   parameter TICK_CYC = `OODT_TICK_CYC
) (
   input wire aclk,
   input wire aresetn,
   input wire [6:0] din_pins,
   input wire [2:0] dout_others,
   output reg [2:0] dout_pins,
   input wire [7:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [`OODT_DELAY_W-1:0] on_delay_setting_ff;
   reg [`OODT_DELAY_W-1:0] off_delay_setting_ff;
   reg [`OODT_FUNC_W*`OODT_NUM_IN-1:0] input_function_select_ff;
   reg [`OODT_FUNC_W*`OODT_NUM_OUT-1:0] output_function_select_ff;
   reg [7:0] awaddr_ff;
   reg aw_full_ff;
   reg [31:0] wdata_ff;
   reg [3:0] wstrb_ff;
   reg w_full_ff;
   reg bvalid_ff;
   reg [1:0] bresp_ff;
   reg rvalid_ff;
   reg [31:0] rdata_ff;
   reg [1:0] rresp_ff;
   reg [31:0] tick_cnt_ff;
   reg tick_ff;
   reg timer_in_ff;
   reg timer_out_ff;
   reg [`OODT_DELAY_W-1:0] delay_cnt_ff;
   reg [`OODT_DELAY_W-1:0] nxt_delay_cnt;
   reg nxt_timer_out;
   reg [`OODT_FUNC_W-1:0] w_func;
   reg [`OODT_DELAY_W-1:0] w_delay;
   reg [`OODT_DELAY_W-1:0] sel_delay;
   reg in_level;
   reg in_assigned;
   reg out_assigned;
   reg [31:0] rd_val;
   reg rd_ok;
   wire [6:0] din_sync;
   wire do_write;
   wire [7:0] waddr;
   wire [7:0] raddr;
   integer k;
   integer ks;
   integer ko;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   oodt_sync #(.WIDTH(`OODT_NUM_IN)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(din_pins),
      .level_out(din_sync)
   );

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   assign s_axi_awready = !aw_full_ff && !bvalid_ff;
   assign s_axi_wready = !w_full_ff && !bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;
   assign waddr = {awaddr_ff[7:2], 2'b00};

   always @* begin
      w_func = wdata_ff[`OODT_FUNC_W-1:0];
      // Out-of-range delay writes clamp to the maximum
      if (wdata_ff[`OODT_DELAY_W-1:0] > `OODT_DELAY_MAX || wdata_ff[31:`OODT_DELAY_W] != 20'h00000) begin
         w_delay = `OODT_DELAY_MAX;
      end else begin
         w_delay = wdata_ff[`OODT_DELAY_W-1:0];
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_ff <= 1'b0;
         w_full_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= 2'h0;
         on_delay_setting_ff <= `OODT_DELAY_RST;
         off_delay_setting_ff <= `OODT_DELAY_RST;
         input_function_select_ff <= {`OODT_NUM_IN{`OODT_FUNC_RST}};
         output_function_select_ff <= {`OODT_NUM_OUT{`OODT_FUNC_RST}};
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
         if (do_write) begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= 2'h0;
            if (waddr == `OODT_ADDR_ON_DELAY) begin
               if (wstrb_ff[1:0] == 2'h3) begin
                  on_delay_setting_ff <= w_delay;
               end
            end else if (waddr == `OODT_ADDR_OFF_DELAY) begin
               if (wstrb_ff[1:0] == 2'h3) begin
                  off_delay_setting_ff <= w_delay;
               end
            end else if (waddr == `OODT_ADDR_IN_SEL) begin
               // Byte n selects function of input n; lane 3 of the next word is ignored
               for (k = 0; k < 4; k = k + 1) begin
                  if (wstrb_ff[k]) begin
                     input_function_select_ff[k*8 +: 8] <= wdata_ff[k*8 +: 8];
                  end
               end
            end else if (waddr == `OODT_ADDR_IN_SEL + 8'h04) begin
               for (k = 0; k < 3; k = k + 1) begin
                  if (wstrb_ff[k]) begin
                     input_function_select_ff[32 + k*8 +: 8] <= wdata_ff[k*8 +: 8];
                  end
               end
            end else if (waddr == `OODT_ADDR_OUT_SEL) begin
               for (k = 0; k < 3; k = k + 1) begin
                  if (wstrb_ff[k]) begin
                     output_function_select_ff[k*8 +: 8] <= wdata_ff[k*8 +: 8];
                  end
               end
            end else if (waddr == `OODT_ADDR_STATUS) begin
               bresp_ff <= 2'h2;
            end else begin
               bresp_ff <= 2'h2;
            end
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign raddr = {s_axi_araddr[7:2], 2'b00};

   always @* begin
      rd_val = 32'h00000000;
      rd_ok = 1'b1;
      if (raddr == `OODT_ADDR_ON_DELAY) begin
         rd_val[`OODT_DELAY_W-1:0] = on_delay_setting_ff;
      end else if (raddr == `OODT_ADDR_OFF_DELAY) begin
         rd_val[`OODT_DELAY_W-1:0] = off_delay_setting_ff;
      end else if (raddr == `OODT_ADDR_IN_SEL) begin
         rd_val = input_function_select_ff[31:0];
      end else if (raddr == `OODT_ADDR_IN_SEL + 8'h04) begin
         rd_val[23:0] = input_function_select_ff[55:32];
      end else if (raddr == `OODT_ADDR_OUT_SEL) begin
         rd_val[23:0] = output_function_select_ff;
      end else if (raddr == `OODT_ADDR_STATUS) begin
         rd_val = {16'h0000, delay_cnt_ff[11:0], in_assigned & out_assigned, 1'b0, timer_out_ff, timer_in_ff};
      end else begin
         rd_ok = 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= 2'h0;
      end else if (rvalid_ff) begin
         if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end else if (s_axi_arvalid) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_val;
         rresp_ff <= rd_ok ? 2'h0 : 2'h2;
      end
   end

   // ----------------------------------------
   // Input selection and 0.1 s tick
   // ----------------------------------------
   always @* begin
      in_level = 1'b0;
      in_assigned = 1'b0;
      out_assigned = 1'b0;
      // Lowest-numbered input carrying the timer code starts the timer
      for (ks = `OODT_NUM_IN - 1; ks >= 0; ks = ks - 1) begin
         if (input_function_select_ff[ks*8 +: 8] == `OODT_FUNC_TIMER_IN) begin
            in_assigned = 1'b1;
            in_level = din_sync[ks];
         end
      end
      for (ks = 0; ks < `OODT_NUM_OUT; ks = ks + 1) begin
         if (output_function_select_ff[ks*8 +: 8] == `OODT_FUNC_TIMER_OUT) begin
            out_assigned = 1'b1;
         end
      end
   end

   // Free-running tick, not gated by any motor state
   always @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_ff <= 32'h00000000;
         tick_ff <= 1'b0;
      end else if (tick_cnt_ff == TICK_CYC - 1) begin
         tick_cnt_ff <= 32'h00000000;
         tick_ff <= 1'b1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
         tick_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // On/off delay engine
   // ----------------------------------------
   always @* begin
      sel_delay = timer_in_ff ? on_delay_setting_ff : off_delay_setting_ff;
      nxt_delay_cnt = delay_cnt_ff;
      nxt_timer_out = timer_out_ff;
      if (!(in_assigned && out_assigned)) begin
         nxt_delay_cnt = `OODT_DELAY_RST;
         nxt_timer_out = 1'b0;
      end else if (in_level != timer_in_ff) begin
         nxt_delay_cnt = `OODT_DELAY_RST;
      end else if (timer_out_ff == timer_in_ff) begin
         nxt_delay_cnt = `OODT_DELAY_RST;
      end else if (tick_ff) begin
         if (delay_cnt_ff >= sel_delay) begin
            nxt_timer_out = timer_in_ff;
            nxt_delay_cnt = `OODT_DELAY_RST;
         end else begin
            nxt_delay_cnt = delay_cnt_ff + 12'h001;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         timer_in_ff <= 1'b0;
         timer_out_ff <= 1'b0;
         delay_cnt_ff <= `OODT_DELAY_RST;
      end else begin
         timer_in_ff <= in_level;
         timer_out_ff <= nxt_timer_out;
         delay_cnt_ff <= nxt_delay_cnt;
      end
   end

   // ----------------------------------------
   // Output routing
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         dout_pins <= 3'h0;
      end else begin
         for (ko = 0; ko < `OODT_NUM_OUT; ko = ko + 1) begin
            if (output_function_select_ff[ko*8 +: 8] == `OODT_FUNC_TIMER_OUT) begin
               dout_pins[ko] <= timer_out_ff;
            end else begin
               dout_pins[ko] <= dout_others[ko];
            end
         end
      end
   end
endmodule // oodt_timer

`default_nettype wire

// [design/oodt_defs.vh]
`ifndef OODT_DEFS_VH
`define OODT_DEFS_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define OODT_ADDR_ON_DELAY  8'h00
`define OODT_ADDR_OFF_DELAY 8'h04
`define OODT_ADDR_IN_SEL    8'h08
`define OODT_ADDR_OUT_SEL   8'h10
`define OODT_ADDR_STATUS    8'h14

// ----------------------------------------
// Field layout and values
// ----------------------------------------
`define OODT_DELAY_W        12
`define OODT_DELAY_MAX      12'hBB8
`define OODT_DELAY_RST      12'h000
`define OODT_FUNC_W         8
`define OODT_FUNC_TIMER_IN  8'h12
`define OODT_FUNC_TIMER_OUT 8'h0C
`define OODT_FUNC_RST       8'h00
`define OODT_NUM_IN         7
`define OODT_NUM_OUT        3

// ----------------------------------------
// Timing
// ----------------------------------------
`define OODT_CLK_HZ         50000000
`define OODT_TICK_MS        100
`define OODT_TICK_CYC       ((`OODT_CLK_HZ / 1000) * `OODT_TICK_MS)

`endif

// [design/oodt_sync.v]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Three-stage pin synchroniser per bit
// ----------------------------------------
module oodt_sync #(
   parameter WIDTH = 7
) (
   input wire aclk,
   input wire aresetn,
   input wire [WIDTH-1:0] pin_in,
   output wire [WIDTH-1:0] level_out
);
   reg [WIDTH-1:0] s1_ff;
   reg [WIDTH-1:0] s2_ff;
   reg [WIDTH-1:0] s3_ff;
   reg [WIDTH-1:0] lvl_ff;
   genvar i;

   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge aclk) begin
            if (!aresetn) begin
               s1_ff[i] <= 1'b0;
               s2_ff[i] <= 1'b0;
               s3_ff[i] <= 1'b0;
               lvl_ff[i] <= 1'b0;
            end else begin
               s1_ff[i] <= pin_in[i];
               s2_ff[i] <= s1_ff[i];
               s3_ff[i] <= s2_ff[i];
               if (s2_ff[i] == s3_ff[i]) begin
                  lvl_ff[i] <= s3_ff[i];
               end
            end
         end
      end
   endgenerate

   assign level_out = lvl_ff;
endmodule // oodt_sync

`default_nettype wire

// [tb/oodt_timer_props.sv]
`timescale 1ns/1ps
`default_nettype none
module oodt_timer_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [2:0] dout_others,
   input wire logic [2:0] dout_pins,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // -----------------
   // Selector shadow
   // -----------------
   logic [2:0] osel_ff;
   logic [6:0] isel_ff;
   wire logic wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire logic idle = isel_ff == 7'h00;
   always @(posedge aclk) begin
      if (!aresetn) begin
         osel_ff <= 3'h0;
         isel_ff <= 7'h00;
      end else if (wr_go) begin
         for (int k = 0; k < 3; k++) begin
            if (s_axi_awaddr == 8'h08) isel_ff[k] <= s_axi_wdata[8*k+:8] == 8'h12;
            if (s_axi_awaddr == 8'h0C) isel_ff[k+4] <= s_axi_wdata[8*k+:8] == 8'h12;
            if (s_axi_awaddr == 8'h10) osel_ff[k] <= s_axi_wdata[8*k+:8] == 8'h0C;
         end
         if (s_axi_awaddr == 8'h08) isel_ff[3] <= s_axi_wdata[31:24] == 8'h12;
      end
   end
   // -----------------
   // Properties
   // -----------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken; wr_go; endsequence
   sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
   wr_answer_a: assert property (wr_taken |=> ##1 s_axi_bvalid) else $error("write answer missing");
   rd_answer_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read answer missing");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write early");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read early");
   pass_thru_a: assert property ($past(aresetn) |-> (~$past(osel_ff, 2) & (dout_pins ^ $past(dout_others))) == 3'h0)
      else $error("plain output wrong");
   idle_off_a: assert property (idle && $past(idle) && $past(idle, 3) |-> (dout_pins & $past(osel_ff, 2)) == 3'h0)
      else $error("idle timer drives output");
endmodule // oodt_timer_props
`default_nettype wire

// [tb/oodt_contacts.sv]
`timescale 1ns/1ps
`default_nettype none
module oodt_contacts (
   input wire logic aclk,
   input wire logic [6:0] level,
   input wire logic chatter,
   output logic [6:0] din_pins
);
   // -----------------
   // Clean or bouncing contacts
   // -----------------
   initial din_pins = 7'h00;
   always @(posedge aclk) begin
      din_pins <= chatter ? level ^ 7'($urandom) : level;
   end
endmodule // oodt_contacts
`default_nettype wire

// [tb/on_off_delay_timer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module on_off_delay_timer_tb;
   localparam int TK = 10;
   logic aclk = 1'b0, aresetn = 1'b0, chatter = 1'b0;
   logic [6:0] level = 7'h00;
   logic [2:0] dout_others = 3'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [6:0] din_pins;
   wire logic [2:0] dout_pins;
   int fails = 0, cmp_count = 0;
   oodt_timer #(.TICK_CYC(TK)) dut_u (
      .aclk, .aresetn, .din_pins, .dout_others, .dout_pins, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   oodt_contacts part_u (.aclk, .level, .chatter, .din_pins);
   initial forever #10 aclk = ~aclk;
   always @(posedge aclk) dout_others <= 3'($urandom);
   function automatic int lo(input int d); return d * TK + 1; endfunction
   function automatic int hi(input int d); return (d + 1) * TK + 8; endfunction
   function automatic logic [31:0] clamp(input logic [31:0] w); return (w > 32'hBB8) ? 32'hBB8 : w; endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (!s_axi_bready && $urandom_range(0, 1)) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid === 1'b1 && s_axi_bready));
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er, "bresp");
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (!s_axi_rready && $urandom_range(0, 1)) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid === 1'b1 && s_axi_rready));
      s_axi_rready <= 1'b0;
      chk(s_axi_rresp, er, "rresp");
      if (er == 2'b00) chk(s_axi_rdata, exp, "rdata");
   endtask
   task automatic step(input int i, input int j, input logic v, input int d);
      int n;
      n = 0;
      level[i] <= v;
      do begin
         @(posedge aclk);
         n++;
      end while (dout_pins[j] !== v && n < hi(d));
      chk(dout_pins[j], v, "late edge");
      chk(n >= lo(d), 1'b1, "early edge");
   endtask
   task automatic hold(input int j, input logic v);
      int bad;
      bad = 0;
      chatter <= 1'b1;
      repeat (100) begin
         @(posedge aclk);
         if (dout_pins[j] !== v) bad++;
      end
      chatter <= 1'b0;
      repeat (8) @(posedge aclk);
      chk(bad, 0, "bounce passed");
   endtask
   task automatic end_sim();
      $display("Compares %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge aclk);
      fails++;
      $display("MISMATCH %0t watchdog", $time);
      end_sim();
   end
   initial begin
      int i, j, d0, d1;
      logic [31:0] w;
      void'($urandom(32'h33AA));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      chk(dout_pins, 3'h0, "reset out");
      for (i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, 2'b00);
      $display("Test defaults done");
      for (i = 0; i < 6; i++) begin
         w = (i < 3) ? $urandom : $urandom_range(0, 3000);
         wr(8'(4 * (i % 2)), w, 2'b00);
         rd(8'(4 * (i % 2)), clamp(w), 2'b00);
      end
      wr(8'h20, w, 2'b10);
      rd(8'h20, 32'h0, 2'b10);
      $display("Test registers done");
      wr(8'h10, 32'h0C, 2'b00);
      level <= 7'h01;
      repeat (4 * TK) @(posedge aclk);
      chk(dout_pins[0], 1'b0, "unassigned");
      level <= 7'h00;
      repeat (2 * TK) @(posedge aclk);
      $display("Test unassigned done");
      for (i = 0; i < 7; i++) begin
         j = i % 3;
         d0 = (i == 0) ? 0 : $urandom_range(3, 5);
         d1 = (i == 0) ? 0 : $urandom_range(3, 5);
         wr(8'h00, d0, 2'b00);
         wr(8'h04, d1, 2'b00);
         wr(8'h08, (i < 4) ? 32'h12 << (8 * i) : 32'h0, 2'b00);
         wr(8'h0C, (i < 4) ? 32'h0 : 32'h12 << (8 * (i - 4)), 2'b00);
         wr(8'h10, 32'h0C << (8 * j), 2'b00);
         repeat (3 * TK) @(posedge aclk);
         if (i > 0) hold(j, 1'b0);
         step(i, j, 1'b1, d0);
         if (i > 0) hold(j, 1'b1);
         step(i, j, 1'b0, d1);
      end
      $display("Test timer done");
      end_sim();
   end
endmodule // on_off_delay_timer_tb
bind oodt_timer oodt_timer_props props_u (
   .aclk, .aresetn, .dout_others, .dout_pins, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready
);
`default_nettype wire
